/* rtl/ufb_pkg.sv */
// Package for the serial frame format and baud configuration block.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
package ufb_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFF_FRAME = 8'h00;
    localparam logic [7:0] OFF_BAUD_HI = 8'h04;
    localparam logic [7:0] OFF_BAUD_LO = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0c;
    localparam logic [7:0] OFF_TXDATA = 8'h10;
    localparam logic [7:0] OFF_RXDATA = 8'h14;
    localparam logic [7:0] OFF_ISTAT = 8'h18;
    localparam logic [7:0] OFF_IMASK = 8'h1c;
    // Frame format field positions
    localparam int FF_MODE_LSB = 6;
    localparam int FF_PAR_LSB = 4;
    localparam int FF_STOP = 3;
    localparam int FF_CSZ_LSB = 1;
    localparam int FF_POL = 0;
    // Control register field positions
    localparam int CTRL_CSZ_TOP = 0;
    localparam int CTRL_DS = 1;
    localparam int CTRL_TXEN = 2;
    localparam int CTRL_RXEN = 3;
    // Receive data register flag positions
    localparam int RXD_PERR = 9;
    localparam int RXD_FERR = 10;
    localparam int RXD_FULL = 11;
    // Interrupt status bit positions
    localparam int EVT_TXDONE = 0;
    localparam int EVT_RXDONE = 1;
    localparam int EVT_PERR = 2;
    localparam int EVT_FERR = 3;
    localparam int EVT_OVR = 4;
    localparam int NUM_EVT = 5;
    // Reset values
    localparam logic [7:0] FRAME_RST = 8'h06;
    localparam logic [3:0] BAUD_HI_RST = 4'h0;
    localparam logic [7:0] BAUD_LO_RST = 8'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Oversample ticks per bit in asynchronous mode
    localparam logic [4:0] OS_NORMAL = 5'h10;
    localparam logic [4:0] OS_DOUBLE = 5'h08;
    // Mode and parity encodings
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] PAR_OFF = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    // Engine states
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufb_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufb_rx_state_t;
endpackage

/* rtl/ufb_uart_cfg.sv */
// Serial transceiver with frame format and baud divisor configuration.
// Assumes an APB master on pclk and a serial line synchronous to pclk.
`timescale 1ns/1ps

// Summary of operation
// R1: Mode field selects async, sync or idle
// R2: Transmitter inserts computed parity bit
// R3: Receiver checks parity, flags mismatch
// R4: Parity field: off, reserved, even, odd
// R5: Stop select gives one or two stops
// R6: Receiver ignores stop select entirely
// R7: Size bits give 5 to 9 data bits
// R8: Polarity picks clock edges for sync data
// R9: Software keeps polarity zero in async
// R10: Divisor is 12 bits over two registers
// R11: Upper baud high bits read zero
// R12: Low byte write reloads prescaler at once
// R13: Software changes divisor only when idle
// R14: Async factor 16, or 8 double speed
// R15: Bit rate is clock over factor times divisor+1
// R16: Reset gives async, 8N1, divisor zero
module ufb_uart_cfg
    import ufb_pkg::*;
#(
    parameter int DIV_W = 12,
    parameter int MAX_BITS = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    output logic sync_serial_clock,
    output logic irq
);
    // Software visible state
    logic [7:0] frame_q; // Frame format control
    logic [3:0] div_hi_q; // Baud divisor bits 11:8
    logic [7:0] div_lo_q; // Baud divisor bits 7:0
    logic [3:0] ctrl_q; // Size top bit, double speed, enables
    logic [NUM_EVT-1:0] istat_q; // Sticky event bits
    logic [NUM_EVT-1:0] istat_d;
    logic [NUM_EVT-1:0] imask_q; // Interrupt mask, same layout
    logic [MAX_BITS-1:0] tx_buf_q; // Transmit holding word
    logic tx_full_q;
    logic [MAX_BITS-1:0] rx_data_q; // Received character
    logic rx_full_q;
    logic rx_perr_q; // Parity error of held character
    logic rx_ferr_q; // Frame error of held character
    // Baud generation
    logic [DIV_W-1:0] presc_q; // Down-counting prescaler
    logic [4:0] os_q; // Transmit oversample phase
    logic [4:0] rx_os_q; // Receive oversample phase
    // Engines
    ufb_tx_state_t tx_state_q;
    ufb_rx_state_t rx_state_q;
    logic [MAX_BITS-1:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic tx_par_q; // Running xor of sent data bits
    logic tx_stop2_q; // Second stop bit still owed
    logic [MAX_BITS-1:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic rx_par_q; // Running xor of received data bits
    logic rx_perr_pend_q; // Parity result of frame in flight

    // Field decode
    logic [1:0] mode;
    logic [1:0] par_mode;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic pol;
    logic [3:0] nbits;
    logic [DIV_W-1:0] divisor;
    logic is_async;
    logic is_sync;
    logic engines_on;
    logic [4:0] factor;
    assign mode = frame_q[FF_MODE_LSB +: 2];
    assign is_async = (mode == MODE_ASYNC); // R1
    assign is_sync = (mode == MODE_SYNC); // R1
    assign engines_on = is_async | is_sync; // R1
    assign par_mode = frame_q[FF_PAR_LSB +: 2];
    // Reserved parity code acts as disabled
    assign par_en = (par_mode == PAR_EVEN) | (par_mode == PAR_ODD); // R4
    assign par_odd = (par_mode == PAR_ODD); // R4
    assign two_stop = frame_q[FF_STOP];
    assign pol = frame_q[FF_POL];
    assign divisor = {div_hi_q, div_lo_q}; // R10
    assign factor = ctrl_q[CTRL_DS] ? OS_DOUBLE : OS_NORMAL; // R14

    // Character size; reserved codes fall back to eight bits
    function automatic logic [3:0] char_bits(input logic [2:0] c);
        case (c)
            3'h0: return 4'h5;
            3'h1: return 4'h6;
            3'h2: return 4'h7;
            3'h7: return 4'h9;
            default: return 4'h8;
        endcase
    endfunction
    assign nbits = char_bits({ctrl_q[CTRL_CSZ_TOP], frame_q[FF_CSZ_LSB +: 2]}); // R7

    // APB phases
    logic setup;
    logic acc;
    logic wr_en;
    logic rd_en;
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready;
    assign wr_en = acc & pwrite;
    assign rd_en = acc & ~pwrite;

    // Read mux and address decode
    logic [31:0] rd_mux;
    logic hit;
    always_comb begin
        rd_mux = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == OFF_FRAME) begin
            rd_mux[7:0] = frame_q;
        end else if (paddr == OFF_BAUD_HI) begin
            rd_mux[3:0] = div_hi_q; // R11
        end else if (paddr == OFF_BAUD_LO) begin
            rd_mux[7:0] = div_lo_q;
        end else if (paddr == OFF_CTRL) begin
            rd_mux[3:0] = ctrl_q;
            rd_mux[4] = tx_full_q;
            rd_mux[5] = (tx_state_q != TX_IDLE);
            rd_mux[6] = (rx_state_q != RX_IDLE);
        end else if (paddr == OFF_TXDATA) begin
            rd_mux[MAX_BITS-1:0] = tx_buf_q;
        end else if (paddr == OFF_RXDATA) begin
            rd_mux[MAX_BITS-1:0] = rx_data_q;
            rd_mux[RXD_PERR] = rx_perr_q;
            rd_mux[RXD_FERR] = rx_ferr_q;
            rd_mux[RXD_FULL] = rx_full_q;
        end else if (paddr == OFF_ISTAT) begin
            rd_mux[NUM_EVT-1:0] = istat_q;
        end else if (paddr == OFF_IMASK) begin
            rd_mux[NUM_EVT-1:0] = imask_q;
        end else begin
            hit = 1'b0;
        end
    end

    // Bus answer: data captured at setup, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= rd_mux;
                pslverr <= ~hit;
            end
        end
    end

    // Configuration registers; unmapped writes change nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_q <= FRAME_RST; // R16
            div_hi_q <= BAUD_HI_RST; // R16
            div_lo_q <= BAUD_LO_RST; // R16
            ctrl_q <= CTRL_RST;
            imask_q <= '0;
        end else if (wr_en) begin
            if (paddr == OFF_FRAME) begin
                frame_q <= pwdata[7:0];
            end else if (paddr == OFF_BAUD_HI) begin
                div_hi_q <= pwdata[3:0]; // R11
            end else if (paddr == OFF_BAUD_LO) begin
                div_lo_q <= pwdata[7:0];
            end else if (paddr == OFF_CTRL) begin
                ctrl_q <= pwdata[3:0];
            end else if (paddr == OFF_IMASK) begin
                imask_q <= pwdata[NUM_EVT-1:0];
            end
        end
    end

    // Prescaler; a new rate applies at once, so frames in flight suffer
    logic tick;
    logic lo_wr;
    assign tick = (presc_q == '0);
    assign lo_wr = wr_en & (paddr == OFF_BAUD_LO);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= '0;
        end else if (lo_wr) begin
            presc_q <= {div_hi_q, pwdata[7:0]}; // R12
        end else if (tick) begin
            presc_q <= divisor; // R15
        end else begin
            presc_q <= presc_q - 1'b1;
        end
    end

    // Transmit oversample phase and synchronous clock
    logic tx_stb;
    logic rx_sync_stb;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_q <= 5'h00;
            sync_serial_clock <= 1'b0;
        end else begin
            if (!is_async || os_q >= factor - 5'h01) begin
                // A phase stranded above a shrunken factor restarts at once
                os_q <= (tick || os_q >= factor) ? 5'h00 : os_q; // R14
            end else if (tick) begin
                os_q <= os_q + 5'h01;
            end
            // Clock runs only in synchronous mode, idles at polarity level
            if (!is_sync) begin
                sync_serial_clock <= pol;
            end else if (tick) begin
                sync_serial_clock <= ~sync_serial_clock; // R8
            end
        end
    end
    // Change edge: rising for polarity 0, falling for polarity 1
    assign tx_stb = is_async ? (tick & (os_q == factor - 5'h01))
                             : (is_sync & tick & (sync_serial_clock == pol)); // R8
    assign rx_sync_stb = is_sync & tick & (sync_serial_clock != pol); // R8

    // Transmit holding word
    logic tx_load;
    logic tx_take;
    assign tx_load = wr_en & (paddr == OFF_TXDATA) & ~tx_full_q & ctrl_q[CTRL_TXEN];
    assign tx_take = tx_stb & (tx_state_q == TX_IDLE) & tx_full_q & engines_on;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_q <= '0;
            tx_full_q <= 1'b0;
        end else if (tx_load) begin
            tx_buf_q <= pwdata[MAX_BITS-1:0];
            tx_full_q <= 1'b1;
        end else if (tx_take) begin
            tx_full_q <= 1'b0;
        end
    end

    // Transmit engine, one step per bit strobe
    logic tx_done;
    assign tx_done = tx_stb & (tx_state_q == TX_STOP) & ~tx_stop2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q <= TX_IDLE;
            serial_tx_pin <= 1'b1;
            tx_sh_q <= '0;
            tx_cnt_q <= 4'h0;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
        end else if (!engines_on) begin
            tx_state_q <= TX_IDLE; // R1
            serial_tx_pin <= 1'b1;
        end else if (tx_stb) begin
            case (tx_state_q)
                TX_IDLE: begin
                    if (tx_full_q) begin
                        serial_tx_pin <= 1'b0;
                        tx_sh_q <= tx_buf_q;
                        tx_par_q <= 1'b0;
                        tx_cnt_q <= 4'h0;
                        tx_state_q <= TX_START;
                    end
                end
                TX_START, TX_DATA: begin
                    if (tx_cnt_q == nbits) begin
                        if (par_en) begin
                            serial_tx_pin <= tx_par_q ^ par_odd; // R2
                            tx_state_q <= TX_PAR;
                        end else begin
                            serial_tx_pin <= 1'b1;
                            tx_stop2_q <= two_stop; // R5
                            tx_state_q <= TX_STOP;
                        end
                    end else begin
                        serial_tx_pin <= tx_sh_q[0];
                        tx_par_q <= tx_par_q ^ tx_sh_q[0]; // R2
                        tx_sh_q <= tx_sh_q >> 1;
                        tx_cnt_q <= tx_cnt_q + 4'h1; // R7
                        tx_state_q <= TX_DATA;
                    end
                end
                TX_PAR: begin
                    serial_tx_pin <= 1'b1;
                    tx_stop2_q <= two_stop; // R5
                    tx_state_q <= TX_STOP;
                end
                default: begin
                    if (tx_stop2_q) begin
                        tx_stop2_q <= 1'b0; // R5
                    end else begin
                        tx_state_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive sample strobe: mid-bit in async, sample edge in sync
    logic [4:0] rx_lim;
    logic rx_stb;
    assign rx_lim = (rx_state_q == RX_START) ? ((factor >> 1) - 5'h01) : (factor - 5'h01);
    assign rx_stb = is_async ? (tick & (rx_os_q == rx_lim)) : rx_sync_stb;

    // Receive engine; only the first stop bit is ever looked at
    logic rx_done;
    logic [MAX_BITS-1:0] rx_aligned;
    assign rx_done = rx_stb & (rx_state_q == RX_STOP);
    assign rx_aligned = rx_sh_q >> (4'(MAX_BITS) - nbits);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_q <= RX_IDLE;
            rx_os_q <= 5'h00;
            rx_sh_q <= '0;
            rx_cnt_q <= 4'h0;
            rx_par_q <= 1'b0;
            rx_perr_pend_q <= 1'b0;
        end else if (!engines_on || !ctrl_q[CTRL_RXEN]) begin
            rx_state_q <= RX_IDLE; // R1
            rx_os_q <= 5'h00;
        end else begin
            if (rx_stb || rx_state_q == RX_IDLE) begin
                rx_os_q <= 5'h00;
            end else if (tick) begin
                rx_os_q <= rx_os_q + 5'h01;
            end
            case (rx_state_q)
                RX_IDLE: begin
                    rx_cnt_q <= 4'h0;
                    rx_par_q <= 1'b0;
                    rx_perr_pend_q <= 1'b0;
                    if (is_async && tick && !serial_rx_pin) begin
                        rx_state_q <= RX_START;
                    end else if (rx_sync_stb && !serial_rx_pin) begin
                        rx_state_q <= RX_DATA;
                    end
                end
                RX_START: begin
                    // A glitch shorter than half a bit is dropped
                    if (rx_stb) begin
                        rx_state_q <= serial_rx_pin ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_stb) begin
                        rx_sh_q <= {serial_rx_pin, rx_sh_q[MAX_BITS-1:1]};
                        rx_par_q <= rx_par_q ^ serial_rx_pin; // R3
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == nbits - 4'h1) begin // R7
                            rx_state_q <= par_en ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_stb) begin
                        rx_perr_pend_q <= rx_par_q ^ serial_rx_pin ^ par_odd; // R3
                        rx_state_q <= RX_STOP;
                    end
                end
                default: begin
                    if (rx_stb) begin
                        rx_state_q <= RX_IDLE; // R6
                    end
                end
            endcase
        end
    end

    // Received character holding; reading it frees it, a new arrival wins
    logic rx_rd;
    assign rx_rd = rd_en & (paddr == OFF_RXDATA);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_q <= '0;
            rx_full_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_ferr_q <= 1'b0;
        end else if (rx_done) begin
            rx_data_q <= rx_aligned;
            rx_full_q <= 1'b1;
            rx_perr_q <= rx_perr_pend_q; // R3
            rx_ferr_q <= ~serial_rx_pin;
        end else if (rx_rd) begin
            rx_full_q <= 1'b0;
        end
    end

    // Events and interrupt; only bits shown by the read are cleared
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EVT-1:0] clr;
    always_comb begin
        evt = '0;
        evt[EVT_TXDONE] = tx_done;
        evt[EVT_RXDONE] = rx_done;
        evt[EVT_PERR] = rx_done & rx_perr_pend_q;
        evt[EVT_FERR] = rx_done & ~serial_rx_pin;
        evt[EVT_OVR] = rx_done & rx_full_q & ~rx_rd;
        clr = (rd_en && paddr == OFF_ISTAT) ? prdata[NUM_EVT-1:0] : '0;
        istat_d = (istat_q & ~clr) | evt;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= '0;
            irq <= 1'b0;
        end else begin
            istat_q <= istat_d;
            irq <= |(istat_d & imask_q);
        end
    end

    // Checks
    property p_lo_reload;
        @(posedge pclk) disable iff (!presetn)
        lo_wr |=> presc_q == {div_hi_q, div_lo_q};
    endproperty
    a_lo_reload: assert property (p_lo_reload) else $error("low write did not reload"); // R12
    property p_hi_rsv;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == OFF_BAUD_HI) |-> prdata[7:4] == 4'h0;
    endproperty
    a_hi_rsv: assert property (p_hi_rsv) else $error("baud high upper bits nonzero"); // R11
    property p_presc;
        @(posedge pclk) disable iff (!presetn)
        (tick && !lo_wr) |=> presc_q == $past(divisor);
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler reload wrong"); // R15
    property p_factor;
        @(posedge pclk) disable iff (!presetn)
        (is_async && $stable(frame_q) && $stable(ctrl_q)) |-> os_q < factor;
    endproperty
    a_factor: assert property (p_factor) else $error("oversample phase out of range"); // R14
    property p_stop2;
        @(posedge pclk) disable iff (!presetn)
        (engines_on && tx_stb && tx_state_q == TX_STOP && tx_stop2_q) |=> tx_state_q == TX_STOP;
    endproperty
    a_stop2: assert property (p_stop2) else $error("second stop bit missing"); // R5
    property p_tx_par;
        @(posedge pclk) disable iff (!presetn)
        (engines_on && tx_stb && tx_state_q == TX_DATA && tx_cnt_q == nbits && par_en)
            |=> serial_tx_pin == ($past(tx_par_q) ^ $past(par_odd));
    endproperty
    a_tx_par: assert property (p_tx_par) else $error("parity bit wrong"); // R2
    property p_rx_par;
        @(posedge pclk) disable iff (!presetn)
        (engines_on && ctrl_q[CTRL_RXEN] && rx_stb && rx_state_q == RX_PAR)
            |=> rx_perr_pend_q == $past(rx_par_q ^ serial_rx_pin ^ par_odd);
    endproperty
    a_rx_par: assert property (p_rx_par) else $error("parity check wrong"); // R3
    property p_rx_stop;
        @(posedge pclk) disable iff (!presetn)
        rx_done |=> rx_state_q == RX_IDLE && rx_full_q;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("receiver waited on stop"); // R6
    property p_mode_off;
        @(posedge pclk) disable iff (!presetn)
        !engines_on |=> tx_state_q == TX_IDLE && serial_tx_pin;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("engine ran in idle mode"); // R1
    property p_sync_edge;
        @(posedge pclk) disable iff (!presetn)
        (is_sync && tx_stb && $stable(frame_q)) |=> sync_serial_clock == ~pol;
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("sync change edge wrong"); // R8
    c_tx_done: cover property (@(posedge pclk) disable iff (!presetn) tx_done);
    c_rx_perr: cover property (@(posedge pclk) disable iff (!presetn) evt[EVT_PERR]);
    c_ovr: cover property (@(posedge pclk) disable iff (!presetn) evt[EVT_OVR]);
    c_sync: cover property (@(posedge pclk) disable iff (!presetn) is_sync && rx_done);
endmodule

/* verification/ufb_remote_model.sv */
// Remote serial transceiver: samples our transmit line, drives our receive line.
// Assumes both lines run synchronous to pclk at a bit period the bench passes in.
`timescale 1ns/1ps
module ufb_remote_model (
    input wire logic pclk,
    input wire logic line_in,
    output logic line_out
);
    logic [15:0] got; // Captured bits, start bit first

    // Line idles high between frames
    initial line_out = 1'b1;

    // Wait for start edge, then sample each bit at its middle
    task automatic grab(input int n, input int per);
        int i;
        for (i = 0; i < 4000 && line_in; i++) @(posedge pclk);
        repeat (per / 2) @(posedge pclk);
        for (i = 0; i < n; i++) begin
            got[i] = line_in;
            repeat (per) @(posedge pclk);
        end
    endtask

    // Send n bits LSB first, one bit period each, then idle high
    task automatic send(input logic [15:0] bits, input int n, input int per);
        int i;
        for (i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (per) @(posedge pclk);
        end
        line_out <= 1'b1;
    endtask
endmodule

/* verification/test_uart_frame_format_and_baud_config.sv */
// Bench for the frame format and baud block: registers over APB, frames via the model.
// Assumes the design answers every APB access and the model shares pclk.
`timescale 1ns/1ps
module test_uart_frame_format_and_baud_config;
    import ufb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready, rx, tx, sck, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int fail_count, num_checks, cyc;

    ufb_uart_cfg dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_rx_pin(rx), .serial_tx_pin(tx),
        .sync_serial_clock(sck), .irq(irq));
    ufb_remote_model pm (.pclk(pclk), .line_in(tx), .line_out(rx));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait count assumed; the hang guard ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    // Wait bounded for the interrupt line
    task automatic wait_irq();
        int t;
        for (t = 0; t < 2000 && irq !== 1'b1; t++) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
    endtask

    task automatic t_regs();
        rdchk(OFF_FRAME, 32'h6);
        rdchk(OFF_BAUD_HI, 32'h0);
        rdchk(OFF_BAUD_LO, 32'h0);
        apb(1'b1, OFF_BAUD_HI, 32'hff);
        rdchk(OFF_BAUD_HI, 32'hf);
        apb(1'b1, OFF_BAUD_LO, 32'ha5);
        rdchk(OFF_BAUD_LO, 32'ha5);
        rdchk(8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Divisor 1, changed only while both engines are idle
        apb(1'b1, OFF_BAUD_HI, 32'h0);
        apb(1'b1, OFF_BAUD_LO, 32'h1);
    endtask

    // Even parity, two stops, 8 bits; bit period follows double speed
    task automatic t_tx(input logic ds);
        apb(1'b1, OFF_FRAME, 32'h2e);
        apb(1'b1, OFF_CTRL, {28'h0, 2'b11, ds, 1'b0});
        apb(1'b1, OFF_IMASK, 32'h1f);
        apb(1'b1, OFF_TXDATA, 32'h5b);
        pm.grab(12, ds ? 16 : 32);
        chk({20'h0, pm.got[11:0]}, {20'h0, 2'b11, 1'b1, 8'h5b, 1'b0});
        wait_irq();
        rdchk(OFF_ISTAT, 32'h1);
        // Interrupt drops at the clearing edge; look once it has settled
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Synchronous mode, polarity 0: frame content, data moves on rising clock
    task automatic t_sync();
        int i, bad;
        logic ptx, psck;
        apb(1'b1, OFF_FRAME, 32'h46);
        apb(1'b1, OFF_TXDATA, 32'ha5);
        pm.grab(10, 4);
        chk({22'h0, pm.got[9:0]}, {22'h0, 1'b1, 8'ha5, 1'b0});
        apb(1'b1, OFF_TXDATA, 32'h3c);
        bad = 0;
        @(negedge pclk);
        ptx = tx;
        psck = sck;
        for (i = 0; i < 60; i++) begin
            @(negedge pclk);
            if (tx !== ptx && !(sck === 1'b1 && psck === 1'b0)) bad++;
            ptx = tx;
            psck = sck;
        end
        chk(bad, 0);
        rdchk(OFF_ISTAT, 32'h1);
    endtask

    // Odd parity frame arriving with a wrong parity bit
    task automatic t_rx();
        apb(1'b1, OFF_FRAME, 32'h36);
        apb(1'b1, OFF_CTRL, 32'hc);
        pm.send({5'h0, 1'b1, 1'b0, 8'h0f, 1'b0}, 11, 32);
        wait_irq();
        rdchk(OFF_RXDATA, 32'ha0f);
        rdchk(OFF_ISTAT, 32'h6);
    endtask

    // Idle mode (mode field 3) keeps the transmit line idle
    task automatic t_mode();
        int i, lows;
        apb(1'b1, OFF_FRAME, 32'hc6);
        apb(1'b1, OFF_TXDATA, 32'h0);
        lows = 0;
        for (i = 0; i < 200; i++) begin
            @(posedge pclk);
            lows += (tx !== 1'b1) + (sck !== 1'b0);
        end
        chk(lows, 0);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Free-running clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Hang guard, well above the fewer than two thousand cycles needed
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx(1'b0);
        t_tx(1'b1);
        t_sync();
        t_rx();
        t_mode();
        tally_and_finish();
    end
endmodule
